//--- pkg/pum_pkg.sv
/*
 * Shared constants and types for the loop multiplier configuration block.
 * Assumes an APB register bus with 32-bit data and byte addresses equal to
 * four times the register index.
 */
package pum_pkg;

    // Register indices; the byte address is four times the index.
    localparam logic [5:0] PUM_IDX_FRAC_LOW = 6'h03;
    localparam logic [5:0] PUM_IDX_FRAC_MID = 6'h04;
    localparam logic [5:0] PUM_IDX_FRAC_HIGH = 6'h05;
    localparam logic [5:0] PUM_IDX_INT_PREDIV = 6'h06;
    localparam logic [5:0] PUM_IDX_POSTDIV = 6'h07;
    localparam logic [5:0] PUM_IDX_PWRDN = 6'h1e;
    localparam logic [5:0] PUM_IDX_STATUS = 6'h20;

    // Reset values.
    localparam logic [7:0] PUM_RST_FRAC_LOW = 8'h21;
    localparam logic [7:0] PUM_RST_FRAC_MID = 8'hfd;
    localparam logic [7:0] PUM_RST_FRAC_HIGH = 8'h36;
    localparam logic [3:0] PUM_RST_INT_MULT = 4'h7;
    localparam logic PUM_RST_PREDIVIDE = 1'b0;
    localparam logic [1:0] PUM_RST_POSTDIV = 2'h2;
    localparam logic PUM_RST_POWERDOWN = 1'b1;

    // Field positions.
    localparam int PUM_POS_PREDIVIDE = 4;
    localparam int PUM_POS_POWERDOWN = 0;
    localparam int PUM_FRAC_HIGH_BITS = 6;
    localparam int PUM_FRAC_BITS = 22;
    localparam int PUM_INT_BITS = 4;
    localparam int PUM_RATIO_BITS = PUM_INT_BITS + PUM_FRAC_BITS;
    localparam int PUM_STAT_POS_AUTO = 0;
    localparam int PUM_STAT_POS_POSTDIV = 1;
    localparam int PUM_STAT_POS_PWRDN = 3;
    localparam int PUM_STAT_POS_INT = 4;

    // Divider counter width and the input_predivide_sel divisor minus one.
    localparam int PUM_DIV_BITS = 4;
    localparam logic [3:0] PUM_PREDIV_BY2_M1 = 4'h1;
    localparam logic [3:0] PUM_DIV_BY1_M1 = 4'h0;

    typedef struct packed {
        logic [3:0] int_mult;
        logic [21:0] frac_mult;
        logic input_predivide_sel;
        logic [1:0] output_postdivide_sel;
    } pum_cfg_t;

    typedef struct packed {
        logic psel;
        logic penable;
        logic pwrite;
        logic [7:0] paddr;
        logic [31:0] pwdata;
    } pum_apb_req_t;

endpackage

//--- hw/pum_tick_divider.sv
/*
 * Divides a stream of one-cycle tick pulses by a programmable divisor.
 * Assumes tick_in is a single-cycle pulse in the mclk domain.
 */
`timescale 1ns/1ps
module pum_tick_divider
    import pum_pkg::*;
(
    input wire logic mclk,
    input wire logic resetn,
    input wire logic ce,
    input wire logic tick_in,
    input wire logic [3:0] div_m1,
    output logic tick_out
);

    logic [PUM_DIV_BITS-1:0] count;

    // A shrinking divisor wraps at the next input tick instead of running the counter around.
    always_ff @(posedge mclk or negedge resetn) begin
        if (!resetn) begin
            count <= 4'h0;
            tick_out <= 1'b0;
        end else if (ce) begin
            if (tick_in && count >= div_m1) begin
                count <= 4'h0;
                tick_out <= 1'b1;
            end else if (tick_in) begin
                count <= count + 4'h1;
                tick_out <= 1'b0;
            end else begin
                tick_out <= 1'b0;
            end
        end
    end

endmodule

//--- hw/pum_config.sv
/*
 * Configuration logic of a fractional-N loop multiplier in manual mode, with
 * an APB register slave, receiver takeover, input_predivide_sel and post divide ticks.
 * Assumes the receiver inputs are in the mclk domain and the two clock pins
 * are slow enough against mclk to be sampled.
 */
// Added by the designer: the APB interface to the registers.
`timescale 1ns/1ps
module pum_config
    import pum_pkg::*;
(
    input wire logic mclk,
    input wire logic resetn,
    input wire logic ce,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic rx_enable,
    input wire pum_cfg_t rx_cfg,
    input wire logic oscillator_clock,
    input wire logic loop_output_clock,
    output pum_cfg_t loop_cfg,
    output logic [25:0] ratio_word,
    output logic auto_mode,
    output logic loop_powerdown,
    output logic loop_input_tick,
    output logic loop_clock_b_tick
);

    ////////////////////////////////////////////////////////////////////////////
    // Address decoding and software registers.

    pum_apb_req_t req;
    logic [7:0] frac_mult_low;
    logic [7:0] frac_mult_mid;
    logic [7:0] frac_mult_high;
    logic [3:0] sw_int_mult;
    logic input_predivide_sel;
    logic [1:0] output_postdivide_sel;
    logic [6:0] rd_decode;
    logic [6:0] wr_decode;
    logic access;
    logic complete;
    logic wr_en;
    logic [31:0] next_prdata;
    logic next_pslverr;

    assign req = '{psel, penable, pwrite, paddr, pwdata};

    // Returns a valid flag above the register index, set only for an aligned address of a mapped register.
    function automatic logic [6:0] decode_index(input logic [7:0] addr);
        logic mapped;
        mapped = (addr[1:0] == 2'b00) && (addr[7:2] inside {PUM_IDX_FRAC_LOW, PUM_IDX_FRAC_MID,
            PUM_IDX_FRAC_HIGH, PUM_IDX_INT_PREDIV, PUM_IDX_POSTDIV, PUM_IDX_PWRDN,
            PUM_IDX_STATUS});
        return {mapped, addr[7:2]};
    endfunction

    assign access = req.psel && req.penable;
    assign complete = access && pready;
    assign rd_decode = decode_index(req.paddr);
    assign wr_decode = decode_index(req.paddr);
    assign wr_en = complete && req.pwrite && wr_decode[6];

    // One wait state: the answer is registered in the first access cycle.
    always_ff @(posedge mclk or negedge resetn) begin
        if (!resetn) begin
            pready <= 1'b0;
            prdata <= 32'h0000_0000;
            pslverr <= 1'b0;
        end else if (ce) begin
            pready <= access && !pready;
            if (access && !pready) begin
                prdata <= next_prdata;
                pslverr <= next_pslverr;
            end
        end
    end

    always_comb begin
        next_prdata = 32'h0000_0000;
        next_pslverr = !rd_decode[6];
        case (rd_decode[5:0])
            PUM_IDX_FRAC_LOW: next_prdata[7:0] = frac_mult_low;
            PUM_IDX_FRAC_MID: next_prdata[7:0] = frac_mult_mid;
            PUM_IDX_FRAC_HIGH: next_prdata[7:0] = frac_mult_high;
            PUM_IDX_INT_PREDIV: begin
                next_prdata[3:0] = sw_int_mult;
                next_prdata[PUM_POS_PREDIVIDE] = input_predivide_sel;
            end
            PUM_IDX_POSTDIV: next_prdata[1:0] = output_postdivide_sel;
            PUM_IDX_PWRDN: next_prdata[PUM_POS_POWERDOWN] = loop_powerdown;
            PUM_IDX_STATUS: begin
                next_prdata[PUM_STAT_POS_AUTO] = auto_mode;
                next_prdata[PUM_STAT_POS_POSTDIV +: 2] = loop_cfg.output_postdivide_sel;
                next_prdata[PUM_STAT_POS_PWRDN] = loop_powerdown;
                next_prdata[PUM_STAT_POS_INT +: 4] = loop_cfg.int_mult;
            end
            default: next_prdata = 32'h0000_0000;
        endcase
        // Unmapped and unaligned addresses read as zero.
        if (!rd_decode[6]) begin
            next_prdata = 32'h0000_0000;
        end
    end

    // Fraction bytes keep all eight bits for read back.
    always_ff @(posedge mclk or negedge resetn) begin
        if (!resetn) begin
            frac_mult_low <= PUM_RST_FRAC_LOW;
            frac_mult_mid <= PUM_RST_FRAC_MID;
            frac_mult_high <= PUM_RST_FRAC_HIGH;
        end else if (ce && wr_en) begin
            if (wr_decode[5:0] == PUM_IDX_FRAC_LOW) begin
                frac_mult_low <= req.pwdata[7:0];
            end
            if (wr_decode[5:0] == PUM_IDX_FRAC_MID) begin
                frac_mult_mid <= req.pwdata[7:0];
            end
            if (wr_decode[5:0] == PUM_IDX_FRAC_HIGH) begin
                frac_mult_high <= req.pwdata[7:0];
            end
        end
    end

    always_ff @(posedge mclk or negedge resetn) begin
        if (!resetn) begin
            sw_int_mult <= PUM_RST_INT_MULT;
            input_predivide_sel <= PUM_RST_PREDIVIDE;
        end else if (ce && wr_en && wr_decode[5:0] == PUM_IDX_INT_PREDIV) begin
            sw_int_mult <= req.pwdata[3:0];
            input_predivide_sel <= req.pwdata[PUM_POS_PREDIVIDE];
        end
    end

    always_ff @(posedge mclk or negedge resetn) begin
        if (!resetn) begin
            output_postdivide_sel <= PUM_RST_POSTDIV;
        end else if (ce && wr_en && wr_decode[5:0] == PUM_IDX_POSTDIV) begin
            output_postdivide_sel <= req.pwdata[1:0];
        end
    end

    always_ff @(posedge mclk or negedge resetn) begin
        if (!resetn) begin
            loop_powerdown <= PUM_RST_POWERDOWN;
        end else if (ce && wr_en && wr_decode[5:0] == PUM_IDX_PWRDN) begin
            loop_powerdown <= req.pwdata[PUM_POS_POWERDOWN];
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Active configuration: software in manual mode, receiver in auto mode except input_predivide_sel, which stays with software.

    pum_cfg_t next_cfg;
    logic [25:0] next_ratio;

    always_comb begin
        next_cfg.int_mult = sw_int_mult;
        next_cfg.frac_mult = {frac_mult_high[PUM_FRAC_HIGH_BITS-1:0], frac_mult_mid,
            frac_mult_low};
        next_cfg.input_predivide_sel = input_predivide_sel;
        next_cfg.output_postdivide_sel = output_postdivide_sel;
        if (rx_enable) begin
            next_cfg.int_mult = rx_cfg.int_mult;
            next_cfg.frac_mult = rx_cfg.frac_mult;
            next_cfg.output_postdivide_sel = rx_cfg.output_postdivide_sel;
        end
        next_ratio = (26'(next_cfg.int_mult) << PUM_FRAC_BITS)
            + 26'(next_cfg.frac_mult);
    end

    always_ff @(posedge mclk or negedge resetn) begin
        if (!resetn) begin
            loop_cfg <= '{PUM_RST_INT_MULT, {PUM_RST_FRAC_HIGH[5:0], PUM_RST_FRAC_MID,
                PUM_RST_FRAC_LOW}, PUM_RST_PREDIVIDE, PUM_RST_POSTDIV};
            ratio_word <= {PUM_RST_INT_MULT, PUM_RST_FRAC_HIGH[5:0], PUM_RST_FRAC_MID,
                PUM_RST_FRAC_LOW};
            auto_mode <= 1'b0;
        end else if (ce) begin
            loop_cfg <= next_cfg;
            ratio_word <= next_ratio;
            auto_mode <= rx_enable;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Pin synchronisers and the input_predivide_sel and post divide tick chains.

    logic [1:0] pin_meta;
    logic [1:0] pin_sync;
    logic [1:0] pin_last;
    logic osc_edge;
    logic loop_edge;
    logic [3:0] prediv_m1;
    logic [3:0] postdiv_m1;

    // Post divide select 0..3 divides by 2, 4, 8 and 16.
    function automatic logic [3:0] postdivide_m1(input logic [1:0] sel);
        return 4'((5'h02 << sel) - 5'h01);
    endfunction

    always_ff @(posedge mclk or negedge resetn) begin
        if (!resetn) begin
            pin_meta <= 2'b00;
            pin_sync <= 2'b00;
            pin_last <= 2'b00;
        end else if (ce) begin
            pin_meta <= {loop_output_clock, oscillator_clock};
            pin_sync <= pin_meta;
            pin_last <= pin_sync;
        end
    end

    assign osc_edge = pin_sync[0] && !pin_last[0];
    assign loop_edge = pin_sync[1] && !pin_last[1] && !loop_powerdown;
    assign prediv_m1 = loop_cfg.input_predivide_sel ? PUM_PREDIV_BY2_M1 : PUM_DIV_BY1_M1;
    assign postdiv_m1 = postdivide_m1(loop_cfg.output_postdivide_sel);

    // The loop input tick is the oscillator after the prescaler.
    pum_tick_divider u_prediv (
        .mclk(mclk),
        .resetn(resetn),
        .ce(ce),
        .tick_in(osc_edge),
        .div_m1(prediv_m1),
        .tick_out(loop_input_tick)
    );

    // The post divided loop output is the clock offered to the consumers.
    pum_tick_divider u_postdiv (
        .mclk(mclk),
        .resetn(resetn),
        .ce(ce),
        .tick_in(loop_edge),
        .div_m1(postdiv_m1),
        .tick_out(loop_clock_b_tick)
    );

    ////////////////////////////////////////////////////////////////////////////
    // Checks.

    default clocking cb @(posedge mclk);
    endclocking
    default disable iff (!resetn);

    chk_manual_source: assert property (ce && !rx_enable |=>
        loop_cfg.int_mult == $past(sw_int_mult)
        && loop_cfg.output_postdivide_sel == $past(output_postdivide_sel))
        else $error("manual mode does not follow software fields");

    chk_frac_assembly: assert property (ce && !rx_enable |=>
        loop_cfg.frac_mult == {$past(frac_mult_high[5:0]), $past(frac_mult_mid),
        $past(frac_mult_low)})
        else $error("fraction not assembled from three registers");

    chk_int_write: assert property (ce && $changed(sw_int_mult) |->
        $past(wr_en) && $past(wr_decode[5:0]) == PUM_IDX_INT_PREDIV)
        else $error("integer multiplier changed without a write");

    chk_ratio_sum: assert property (ratio_word ==
        {loop_cfg.int_mult, loop_cfg.frac_mult})
        else $error("ratio word is not integer plus fraction");

    chk_predivide_one: assert property (ce && osc_edge
        && !loop_cfg.input_predivide_sel |=> loop_input_tick)
        else $error("divide by one lost an oscillator tick");

    chk_predivide_two: assert property (ce && loop_input_tick
        && loop_cfg.input_predivide_sel && $stable(loop_cfg) |-> !$past(loop_input_tick))
        else $error("divide by two gave adjacent ticks");

    chk_postdiv_auto: assert property (ce && rx_enable |=>
        loop_cfg.output_postdivide_sel == $past(rx_cfg.output_postdivide_sel))
        else $error("receive mode post divide not taken from receiver");

    chk_auto_mode: assert property (ce && rx_enable |=> auto_mode
        && loop_cfg.int_mult == $past(rx_cfg.int_mult)
        && loop_cfg.frac_mult == $past(rx_cfg.frac_mult))
        else $error("receiver does not control the loop");

    chk_powerdown: assert property (ce && wr_en && wr_decode[5:0] == PUM_IDX_PWRDN
        |=> loop_powerdown == $past(req.pwdata[0]))
        else $error("power down bit not written");

    chk_frac_upper: assert property (ce && $past(ce) && !rx_enable
        && !$past(rx_enable) && $stable(frac_mult_high[5:0])
        |=> $stable(loop_cfg.frac_mult[21:16]))
        else $error("upper fraction bits leaked into the ratio");

    chk_apb_answer: assert property (ce && access && !pready |=> pready)
        else $error("bus answer not given after one wait state");

endmodule

//--- sim/tb_top.sv
/*
 * Self-checking testbench for the loop multiplier configuration block.
 * Assumes the pum_config design and pum_pkg are compiled first; the bench
 * is the APB master and drives the receiver and both clock pins itself.
 */
`timescale 1ns/1ps
module tb_top;
    import pum_pkg::*;

    typedef struct packed {
        logic [7:0] addr;
        logic [7:0] rst;
        logic [7:0] wdata;
        logic [7:0] rdata;
        logic err;
    } pum_row_t;

    logic mclk = 1'b0;
    logic resetn = 1'b0;
    logic ce = 1'b1;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0000_0000;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
    logic rx_enable = 1'b0;
    pum_cfg_t rx_cfg = '0;
    logic oscillator_clock = 1'b0;
    logic loop_output_clock = 1'b0;
    pum_cfg_t loop_cfg;
    logic [25:0] ratio_word;
    logic auto_mode;
    logic loop_powerdown;
    logic loop_input_tick;
    logic loop_clock_b_tick;
    int n_mismatch = 0;
    int checks = 0;
    int n_in = 0;
    int n_out = 0;
    logic [31:0] rd;
    logic er;
    // Reset reads first, then a write and read-back per row; the status row is read only.
    pum_row_t rows[9] = '{
        '{8'h0c, 8'h21, 8'hba, 8'hba, 1'b0}, '{8'h10, 8'hfd, 8'h49, 8'h49, 1'b0},
        '{8'h14, 8'h36, 8'hcc, 8'hcc, 1'b0}, '{8'h18, 8'h07, 8'h18, 8'h18, 1'b0},
        '{8'h1c, 8'h02, 8'h03, 8'h03, 1'b0}, '{8'h78, 8'h01, 8'h00, 8'h00, 1'b0},
        '{8'h40, 8'h00, 8'h5a, 8'h00, 1'b1}, '{8'h0d, 8'h00, 8'h5a, 8'h00, 1'b1},
        '{8'h80, 8'h7c, 8'hff, 8'h86, 1'b0}};

    pum_config dut_u (.mclk(mclk), .resetn(resetn), .ce(ce), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .prdata(prdata), .pready(pready), .pslverr(pslverr), .rx_enable(rx_enable),
        .rx_cfg(rx_cfg), .oscillator_clock(oscillator_clock),
        .loop_output_clock(loop_output_clock), .loop_cfg(loop_cfg),
        .ratio_word(ratio_word), .auto_mode(auto_mode), .loop_powerdown(loop_powerdown),
        .loop_input_tick(loop_input_tick), .loop_clock_b_tick(loop_clock_b_tick));

    always #25 mclk = ~mclk;

    always @(posedge mclk) begin
        if (loop_input_tick === 1'b1) n_in++;
        if (loop_clock_b_tick === 1'b1) n_out++;
    end

    ////////////////////////////////////////////////////////////////////////////
    task automatic fail(input string msg);
        n_mismatch++;
        $display("mismatch at %0t: %s", $time, msg);
    endtask

    task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
        checks++;
        if (got !== exp) fail($sformatf("%s got %h expected %h", what, got, exp));
    endtask

    // One APB transfer; pready is sampled at the rising edge before any release.
    task automatic apb(input logic [7:0] a, input logic w, input logic [31:0] d);
        int n;
        n = 0;
        @(posedge mclk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge mclk);
        penable <= 1'b1;
        do begin
            @(posedge mclk);
            n++;
        end while (pready !== 1'b1 && n < 20);
        if (n >= 20) fail("no pready");
        rd = prdata;
        er = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    // Makes slow pulses on one pin and counts the resulting ticks.
    task automatic tick_run(input int edges, input bit loop_side, input int exp);
        n_in = 0;
        n_out = 0;
        repeat (edges) begin
            repeat (3) @(posedge mclk);
            if (loop_side) loop_output_clock <= 1'b1;
            else oscillator_clock <= 1'b1;
            repeat (3) @(posedge mclk);
            if (loop_side) loop_output_clock <= 1'b0;
            else oscillator_clock <= 1'b0;
        end
        repeat (10) @(posedge mclk);
        chk(loop_side ? n_out : n_in, exp, "tick count");
    endtask

    task automatic summarize;
        $display("checks %0d n_mismatch %0d", checks, n_mismatch);
        if (n_mismatch == 0 && checks > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask

    ////////////////////////////////////////////////////////////////////////////
    initial begin
        repeat (20000) @(posedge mclk);
        fail("timeout");
        summarize();
    end

    initial begin
        repeat (10) @(posedge mclk);
        resetn <= 1'b1;
        @(posedge mclk);
        chk(loop_cfg, {4'h7, 22'h36_fd21, 1'b0, 2'h2}, "reset cfg");
        chk(ratio_word, {4'h7, 22'h36_fd21}, "reset ratio");
        chk(loop_powerdown, 1'b1, "reset powerdown");
        foreach (rows[i]) begin
            apb(rows[i].addr, 1'b0, 32'h0000_0000);
            chk(rd, rows[i].rst, "reset read");
            chk(er, rows[i].err, "reset err");
        end
        foreach (rows[i]) begin
            apb(rows[i].addr, 1'b1, {24'h00_0000, rows[i].wdata});
            chk(er, rows[i].err, "write err");
            apb(rows[i].addr, 1'b0, 32'h0000_0000);
            chk(rd, rows[i].rdata, "readback");
            chk(er, rows[i].err, "read err");
        end
        chk(loop_cfg, {4'h8, 22'h0c_49ba, 1'b1, 2'h3}, "manual cfg");
        chk(ratio_word, {4'h8, 22'h0c_49ba}, "manual ratio");
        chk(loop_powerdown, 1'b0, "powered up");
        apb(8'h14, 1'b1, 32'h0000_004c);
        apb(8'h14, 1'b0, 32'h0000_0000);
        chk(rd, 32'h0000_004c, "upper bits kept");
        chk(loop_cfg, {4'h8, 22'h0c_49ba, 1'b1, 2'h3}, "upper bits ignored");
        tick_run(16, 1'b0, 8);
        tick_run(32, 1'b1, 2);
        rx_cfg <= '{int_mult: 4'h9, frac_mult: 22'h12_3456, input_predivide_sel: 1'b0,
            output_postdivide_sel: 2'h0};
        rx_enable <= 1'b1;
        repeat (2) @(posedge mclk);
        chk(auto_mode, 1'b1, "auto mode");
        chk(loop_cfg, {4'h9, 22'h12_3456, 1'b1, 2'h0}, "auto cfg");
        chk(ratio_word, {4'h9, 22'h12_3456}, "auto ratio");
        apb(8'h1c, 1'b0, 32'h0000_0000);
        chk(rd, 32'h0000_0003, "sw postdiv kept");
        apb(8'h80, 1'b0, 32'h0000_0000);
        chk(rd, 32'h0000_0091, "auto status");
        tick_run(32, 1'b1, 16);
        rx_enable <= 1'b0;
        repeat (2) @(posedge mclk);
        chk(auto_mode, 1'b0, "manual again");
        chk(loop_cfg, {4'h8, 22'h0c_49ba, 1'b1, 2'h3}, "manual back");
        // With the clock enable low the receiver request must not be taken.
        ce <= 1'b0;
        rx_enable <= 1'b1;
        repeat (3) @(posedge mclk);
        chk(auto_mode, 1'b0, "ce freeze");
        chk(loop_cfg, {4'h8, 22'h0c_49ba, 1'b1, 2'h3}, "ce freeze cfg");
        rx_enable <= 1'b0;
        ce <= 1'b1;
        apb(8'h18, 1'b1, 32'h0000_0008);
        tick_run(16, 1'b0, 16);
        apb(8'h78, 1'b1, 32'h0000_0001);
        repeat (2) @(posedge mclk);
        chk(loop_powerdown, 1'b1, "powered down");
        tick_run(8, 1'b1, 0);
        resetn <= 1'b0;
        repeat (2) @(posedge mclk);
        resetn <= 1'b1;
        @(posedge mclk);
        chk(loop_cfg, {4'h7, 22'h36_fd21, 1'b0, 2'h2}, "second reset cfg");
        chk(ratio_word, {4'h7, 22'h36_fd21}, "second reset ratio");
        chk(loop_powerdown, 1'b1, "second reset powerdown");
        summarize();
    end
endmodule
